/* rtl/nvf_event_flags.sv */
// Purpose: sticky status flags of a non-volatile memory controller
// Assumes: event inputs are synchronous one-cycle pulses
// Notes:   flags at offset 0, ecc info at offset 4; ecc read clears ecc flags
//
// Overview of operation
// - command done sets bit 0, write-one clears
// - address error sets bit 1, write-one clears
// - programming error sets bit 2, write-one clears
// - lock error sets bit 3, write-one clears
// - single ecc error sets bit 4
// - dual ecc error sets bit 5
// - memory error sets bit 6, write-one clears
// - ecc info read clears both ecc flags
// - writing one clears done/addr/prog/lock/mem flags
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
module nvf_event_flags #(
  parameter int ADDR_W = 8,   // register address width
  parameter int ECCA_W = 24   // width of captured ecc address
) (
  input  wire logic              sys_clk,     // 250 MHz system clock
  input  wire logic              nrst,        // async reset, active low
  input  wire logic [ADDR_W-1:0] reg_addr,    // register byte address
  input  wire logic [31:0]       reg_wdata,   // register write data
  input  wire logic              reg_wr,      // write strobe
  input  wire logic              reg_rd,      // read strobe
  output logic      [31:0]       reg_rdata,   // read data, cycle after strobe
  input  wire logic              cmd_done,    // command finished pulse
  input  wire logic              addr_err,    // address error pulse
  input  wire logic              prog_err,    // programming error pulse
  input  wire logic              lock_err,    // lock error pulse
  input  wire logic              ecc_single,  // single-bit ecc error pulse
  input  wire logic              ecc_dual,    // double-bit ecc error pulse
  input  wire logic [ECCA_W-1:0] ecc_addr,    // address of ecc error
  input  wire logic              mem_err,     // memory error pulse
  output logic      [7:0]        event_flags  // live flag vector
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (ADDR_W < 3 || ADDR_W > 8) begin : g_chk_addr
    $error("ADDR_W must be 3..8");
  end
  if (ECCA_W < 1 || ECCA_W > 31) begin : g_chk_ecca
    $error("ECCA_W must be 1..31");
  end

  // ****************************************
  // decode
  // ****************************************
  // address match, used for both flag and info register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs[ADDR_W-1:0]);
  endfunction

  logic       wr_flags;   // write to flag register
  logic       rd_info;    // read of ecc info register
  logic [7:0] set_vec;    // per-bit set pulses
  logic [7:0] clr_vec;    // per-bit clear strobes

  assign wr_flags = reg_wr && hit(reg_addr, nvf_pkg::FLAGS_OFS);
  assign rd_info  = reg_rd && hit(reg_addr, nvf_pkg::ECC_INFO_OFS);

  // event pulses by bit position
  always_comb begin
    set_vec = 8'h00;
    set_vec[nvf_pkg::DONE_BIT] = cmd_done;
    set_vec[nvf_pkg::ADDR_BIT] = addr_err;
    set_vec[nvf_pkg::PROG_BIT] = prog_err;
    set_vec[nvf_pkg::LOCK_BIT] = lock_err;
    set_vec[nvf_pkg::ECCS_BIT] = ecc_single;
    set_vec[nvf_pkg::ECCD_BIT] = ecc_dual;
    set_vec[nvf_pkg::MEM_BIT]  = mem_err;
  end

  // clear: ones written to w1c bits, zeros ignored; ecc bits by info read
  always_comb begin
    clr_vec = wr_flags ? (reg_wdata[7:0] & nvf_pkg::W1C_MASK) : 8'h00;
    if (rd_info) begin
      clr_vec = clr_vec | nvf_pkg::R2C_MASK;
    end
  end

  // ****************************************
  // flag bits
  // ****************************************
  // bit 7 stays reserved and reads zero
  for (genvar i = 0; i < 7; i++) begin : g_flag
    nvf_flag_bit u_bit (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .set_evt (set_vec[i]),
      .clr     (clr_vec[i]),
      .flag    (event_flags[i])
    );
  end
  assign event_flags[7] = 1'b0;

  // ****************************************
  // ecc info capture
  // ****************************************
  logic [ECCA_W-1:0] ecc_addr_q;  // last ecc error address
  logic              ecc_dual_q;  // last ecc error was dual
  // latest error wins; info kept until overwritten
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ecc_addr_q <= nvf_pkg::ADDR_RST[ECCA_W-1:0];
      ecc_dual_q <= 1'b0;
    end else if (ecc_single || ecc_dual) begin
      ecc_addr_q <= ecc_addr;
      ecc_dual_q <= ecc_dual;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, nvf_pkg::FLAGS_OFS)) begin
        reg_rdata <= {24'h00_0000, event_flags};
      end else if (hit(reg_addr, nvf_pkg::ECC_INFO_OFS)) begin
        reg_rdata <= {ecc_dual_q, {(31-ECCA_W){1'b0}}, ecc_addr_q};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  done_set_a:   assert property (cmd_done |=> event_flags[0])
    else $error("done flag not set");
  addr_set_a:   assert property (addr_err |=> event_flags[1])
    else $error("address flag not set");
  prog_set_a:   assert property (prog_err |=> event_flags[2])
    else $error("program flag not set");
  lock_set_a:   assert property (lock_err |=> event_flags[3])
    else $error("lock flag not set");
  ecc_single_a: assert property (ecc_single |=> event_flags[4])
    else $error("ecc single flag not set");
  ecc_dual_a:   assert property (ecc_dual |=> event_flags[5])
    else $error("ecc dual flag not set");
  mem_set_a:    assert property (mem_err |=> event_flags[6])
    else $error("memory flag not set");
  ecc_rd_clr_a: assert property (rd_info && !ecc_single && !ecc_dual
                                 |=> event_flags[5:4] == 2'b00)
    else $error("ecc read did not clear");
  ecc_wr_keep_a: assert property (wr_flags && !rd_info && event_flags[4]
                                  |=> event_flags[4])
    else $error("write cleared ecc flag");
  w1c_clear_a:  assert property (wr_flags && reg_wdata[0] && !cmd_done
                                 |=> !event_flags[0])
    else $error("write one did not clear");
  w0_keep_a:    assert property (wr_flags && !reg_wdata[6] && event_flags[6]
                                 |=> event_flags[6])
    else $error("zero write changed flag");
  set_wins_a:   assert property (wr_flags && reg_wdata[1] && addr_err
                                 |=> $stable(event_flags[1]) || event_flags[1])
    else $error("clear beat set");
  rd_latency_a: assert property (reg_rd && hit(reg_addr, nvf_pkg::FLAGS_OFS)
                                 |=> reg_rdata[7:0] == $past(event_flags))
    else $error("flag read data wrong");

  done_clr_c:   cover property (cmd_done ##[1:20] wr_flags && reg_wdata[0]);
  ecc_clr_c:    cover property (ecc_dual ##[1:20] rd_info);
  collide_c:    cover property (wr_flags && reg_wdata[3] && lock_err);
endmodule

/* rtl/nvf_flag_bit.sv */
// Purpose: one sticky event flag with set priority over clear
// Assumes: set and clear are single-cycle strobes
// Notes:   used once per flag bit by the main block
`timescale 1ns/1ns
module nvf_flag_bit (
  input  wire logic sys_clk,  // system clock
  input  wire logic nrst,     // async reset, active low
  input  wire logic set_evt,  // event pulse
  input  wire logic clr,      // clear strobe
  output logic      flag      // sticky flag
);
  // ****************************************
  // flag storage
  // ****************************************
  // set wins so an event coincident with a clear is never lost
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule

/* rtl/nvf_pkg.sv */
// Purpose: constants shared by the memory controller event flag block
// Assumes: one clock, plain register port with byte-address words
// Notes:   offsets are word aligned byte addresses
package nvf_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] FLAGS_OFS    = 8'h00;  // event flag register
  localparam logic [7:0] ECC_INFO_OFS = 8'h04;  // ecc error info register
  // ****************************************
  // field positions
  // ****************************************
  localparam int DONE_BIT  = 0;  // command done
  localparam int ADDR_BIT  = 1;  // address error
  localparam int PROG_BIT  = 2;  // programming error
  localparam int LOCK_BIT  = 3;  // lock error
  localparam int ECCS_BIT  = 4;  // ecc single error
  localparam int ECCD_BIT  = 5;  // ecc dual error
  localparam int MEM_BIT   = 6;  // memory error
  localparam int FLAG_W    = 8;  // flag register width
  // write-one-to-clear mask: done, addr, prog, lock, mem
  localparam logic [7:0] W1C_MASK   = 8'h4F;
  // read-to-clear mask: both ecc flags
  localparam logic [7:0] R2C_MASK   = 8'h30;
  localparam logic [7:0] FLAGS_RST  = 8'h00;  // reset value of flags
  localparam logic [31:0] ADDR_RST  = 32'h0000_0000;  // reset of ecc address
endpackage

/* verif/tb_top.sv */
// Purpose: self-checking bench for the event flag block
// Assumes: read data one cycle after the strobe, flags one cycle after events
// Notes:   no open waits; every latency is fixed by the port contract
`timescale 1ns/1ns
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic        sys_clk;      // 250 MHz clock
  logic        nrst;         // async reset, active low
  logic [7:0]  reg_addr;     // register byte address
  logic [31:0] reg_wdata;    // write data
  logic        reg_wr;       // write strobe
  logic        reg_rd;       // read strobe
  logic [31:0] reg_rdata;    // read data
  logic [6:0]  ev;           // event pulses in flag bit order
  logic [23:0] ecc_addr;     // ecc error address
  logic [7:0]  event_flags;  // live flags
  logic [31:0] rv;           // last read value
  logic [7:0]  ex;           // expected flags
  int          n_errors;     // mismatch count
  int          compares;     // comparison count
  // ****************************************
  // design under test
  // ****************************************
  nvf_event_flags #(.ADDR_W(8), .ECCA_W(24)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_done(ev[0]),
    .addr_err(ev[1]), .prog_err(ev[2]), .lock_err(ev[3]), .ecc_single(ev[4]),
    .ecc_dual(ev[5]), .ecc_addr(ecc_addr), .mem_err(ev[6]), .event_flags(event_flags));
  // free running clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  // compare and count; four-state equality so unknowns fail
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // one-cycle read strobe; data taken in the following cycle only
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // one-cycle event pulse, flags looked at once the edge has landed
  task pulse(input logic [6:0] m, input logic [23:0] a);
    @(posedge sys_clk);
    ev       <= m;
    ecc_addr <= a;
    @(posedge sys_clk);
    ev       <= 7'h00;
    #1;
  endtask
  // counts, verdict, end of run
  task finish_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {nrst, reg_addr, reg_wdata, reg_wr, reg_rd, ev, ecc_addr} = '0;
    n_errors = 0;
    compares = 0;
    ex = 8'h00;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    chk("flags at reset", {24'h0, event_flags}, 32'h0);
    rd(8'h04);
    chk("info at reset", rv, 32'h0);
    $display("test reset done");
    // each event sets only its own bit; ecc address moves with i
    for (int i = 0; i < 7; i++) begin
      pulse(7'(1 << i), 24'h00AB00 + 24'(i));
      ex = ex | 8'(1 << i);
      chk("flag set", {24'h0, event_flags}, {24'h0, ex});
    end
    $display("test set done");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    wr(8'h08, 32'hFF);
    #1 chk("zero and stray writes", {24'h0, event_flags}, 32'h7F);
    wr(8'h00, 32'hFF);
    #1 chk("write one clear", {24'h0, event_flags}, 32'h30);
    rd(8'h08);
    chk("unmapped read", rv, 32'h0);
    rd(8'h00);
    chk("flag read", rv, 32'h30);
    // ecc flags survive writes and flag reads; only the info read clears
    rd(8'h04);
    chk("info dual", rv, 32'h8000AB05);
    #4 chk("ecc cleared", {24'h0, event_flags}, 32'h0);
    pulse(7'h10, 24'h123456);
    rd(8'h04);
    chk("info single", rv, 32'h00123456);
    $display("test clear done");
    // event in the same cycle as its clear must win
    @(posedge sys_clk);
    ev        <= 7'h01;
    reg_addr  <= 8'h00;
    reg_wdata <= 32'h1;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    ev        <= 7'h00;
    reg_wr    <= 1'b0;
    #1 chk("set beats clear", {24'h0, event_flags}, 32'h01);
    wr(8'h00, 32'h1);
    #1 chk("done cleared", {24'h0, event_flags}, 32'h0);
    $display("test race done");
    finish_test;
  end
endmodule
